// *** logic/serial_dac_word_loader_defines.vh ***
// constants shared by the serial dac word loader and its fifo
`ifndef SERIAL_DAC_WORD_LOADER_DEFINES_VH
`define SERIAL_DAC_WORD_LOADER_DEFINES_VH

// ------------------------------------------------------------
// frame and latch layout
// ------------------------------------------------------------
`define SHIFT_WIDTH         16
`define LATCH_WIDTH         12
`define CODE_WIDTH          10
`define LATCH_MSB           11
`define LATCH_LSB           0
`define CODE_MSB            11
`define CODE_LSB            2
`define SHIFT_MSB           15
`define BIT_COUNT_WIDTH     5
`define BIT_COUNT_MAX       5'h10
`define BIT_COUNT_ZERO      5'h00
`define BIT_COUNT_ONE       5'h01
`define MIN_FRAME_BITS      5'h0c

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SHIFT_RESET         16'h0000
`define LATCH_RESET         12'h000
`define SYNC_RESET          1'b0
`define CS_SYNC_RESET       1'b1
`define DOUT_RESET          1'b0
`define PULSE_RESET         1'b0

// ------------------------------------------------------------
// fifo geometry
// ------------------------------------------------------------
`define FIFO_DEPTH          8
`define FIFO_ADDR_WIDTH     3
`define FIFO_PTR_ONE        3'h1
`define FIFO_PTR_ZERO       3'h0
`define FIFO_COUNT_ZERO     4'h0
`define FIFO_COUNT_ONE      4'h1
`define FIFO_COUNT_FULL     4'h8

// ------------------------------------------------------------
// timing, system clock and update period
// ------------------------------------------------------------
`define CLK_SYS_PERIOD_NS   40
`define UPDATE_PERIOD_NS    820
`define UPDATE_PERIOD_CYC   ((`UPDATE_PERIOD_NS + `CLK_SYS_PERIOD_NS - 1) / `CLK_SYS_PERIOD_NS)

`endif

// *** logic/word_fifo.v ***
// small synchronous fifo with valid and ready on both sides
`include "serial_dac_word_loader_defines.vh"
`default_nettype none

module word_fifo #(
    parameter WIDTH      = `LATCH_WIDTH,
    parameter DEPTH      = `FIFO_DEPTH,
    parameter ADDR_WIDTH = `FIFO_ADDR_WIDTH
) (
    // clock and reset
    input  wire                  clk_sys,
    input  wire                  reset,
    // filling side
    input  wire                  in_valid,
    output wire                  in_ready,
    input  wire [WIDTH-1:0]      in_data,
    // draining side
    output wire                  out_valid,
    input  wire                  out_ready,
    output wire [WIDTH-1:0]      out_data,
    // level
    output wire [ADDR_WIDTH:0]   level
);

    reg  [WIDTH-1:0]      mem_reg [0:DEPTH-1];
    reg  [ADDR_WIDTH-1:0] wr_ptr_reg;
    reg  [ADDR_WIDTH-1:0] rd_ptr_reg;
    reg  [ADDR_WIDTH:0]   count_reg;
    wire                  push;
    wire                  pop;

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    assign in_ready  = (count_reg != DEPTH[ADDR_WIDTH:0]);
    assign out_valid = (count_reg != `FIFO_COUNT_ZERO);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_reg[rd_ptr_reg];
    assign level     = count_reg;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // ------------------------------------------------------------
    // pointers and count
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wr_ptr_reg <= `FIFO_PTR_ZERO;
            rd_ptr_reg <= `FIFO_PTR_ZERO;
            count_reg  <= `FIFO_COUNT_ZERO;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + `FIFO_PTR_ONE;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + `FIFO_PTR_ONE;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + `FIFO_COUNT_ONE;
            end else if (pop & ~push) begin
                count_reg <= count_reg - `FIFO_COUNT_ONE;
            end
        end
    end

endmodule // word_fifo

`default_nettype wire

// *** logic/serial_dac_word_loader.v ***
// serial load path of a ten bit voltage output dac
`include "serial_dac_word_loader_defines.vh"
`default_nettype none

module serial_dac_word_loader (
    // clock and reset
    input  wire                          clk_sys,
    input  wire                          reset,
    // serial pins
    input  wire                          chip_select_n,
    input  wire                          serial_clock,
    input  wire                          serial_data_in,
    output wire                          serial_data_out,
    // converter core side
    input  wire                          converter_ready,
    output wire [`LATCH_WIDTH-1:0]       dac_latch,
    output wire [`CODE_WIDTH-1:0]        dac_code,
    output wire                          dac_update,
    // status
    output wire                          load_ready,
    output wire                          frame_dropped,
    output wire                          frame_short
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg                          cs_meta_reg;
    reg                          cs_sync_reg;
    reg                          cs_last_reg;
    reg                          clk_meta_reg;
    reg                          clk_sync_reg;
    reg                          clk_last_reg;
    reg                          din_meta_reg;
    reg                          din_sync_reg;

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cs_meta_reg  <= `CS_SYNC_RESET;
            cs_sync_reg  <= `CS_SYNC_RESET;
            cs_last_reg  <= `CS_SYNC_RESET;
            clk_meta_reg <= `SYNC_RESET;
            clk_sync_reg <= `SYNC_RESET;
            clk_last_reg <= `SYNC_RESET;
            din_meta_reg <= `SYNC_RESET;
            din_sync_reg <= `SYNC_RESET;
        end else begin
            cs_meta_reg  <= chip_select_n;
            cs_sync_reg  <= cs_meta_reg;
            cs_last_reg  <= cs_sync_reg;
            clk_meta_reg <= serial_clock;
            clk_sync_reg <= clk_meta_reg;
            clk_last_reg <= clk_sync_reg;
            din_meta_reg <= serial_data_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    wire selected;
    wire clk_rise;
    wire clk_fall;
    wire cs_rise;

    assign selected = ~cs_sync_reg;
    assign clk_rise = clk_sync_reg & ~clk_last_reg & selected;
    assign clk_fall = ~clk_sync_reg & clk_last_reg & selected;
    assign cs_rise  = cs_sync_reg & ~cs_last_reg;

    // ------------------------------------------------------------
    // input shift register
    // ------------------------------------------------------------
    reg  [`SHIFT_WIDTH-1:0]      shift_reg;
    reg  [`SHIFT_WIDTH-1:0]      shift_next;
    reg  [`BIT_COUNT_WIDTH-1:0]  bit_count_reg;
    reg  [`BIT_COUNT_WIDTH-1:0]  bit_count_next;

    always @* begin
        shift_next     = shift_reg;
        bit_count_next = bit_count_reg;
        if (clk_rise) begin
            // msb first: new bits enter at the bottom
            shift_next = {shift_reg[`SHIFT_MSB-1:0], din_sync_reg};
            if (bit_count_reg != `BIT_COUNT_MAX) begin
                bit_count_next = bit_count_reg + `BIT_COUNT_ONE;
            end
        end
        if (cs_rise) begin
            bit_count_next = `BIT_COUNT_ZERO;
        end
    end

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            shift_reg     <= `SHIFT_RESET;
            bit_count_reg <= `BIT_COUNT_ZERO;
        end else begin
            shift_reg     <= shift_next;
            bit_count_reg <= bit_count_next;
        end
    end

    // ------------------------------------------------------------
    // serial data out
    // ------------------------------------------------------------
    reg                          dout_reg;
    reg                          dout_next;

    always @* begin
        dout_next = dout_reg;
        if (clk_fall) begin
            // oldest bit of the register, shifted in fifteen rising clocks earlier
            dout_next = shift_reg[`SHIFT_MSB];
        end
    end

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dout_reg <= `DOUT_RESET;
        end else begin
            dout_reg <= dout_next;
        end
    end

    assign serial_data_out = dout_reg;

    // ------------------------------------------------------------
    // frame capture into the fifo
    // ------------------------------------------------------------
    wire [`LATCH_WIDTH-1:0]      frame_word;
    wire                         fifo_in_ready;
    wire                         fifo_out_valid;
    wire [`LATCH_WIDTH-1:0]      fifo_out_data;
    wire                         fifo_pop;
    reg                          dropped_reg;
    reg                          short_reg;

    // last twelve shifted bits, whatever the frame length
    assign frame_word = shift_reg[`LATCH_MSB:`LATCH_LSB];

    word_fifo #(
        .WIDTH      (`LATCH_WIDTH),
        .DEPTH      (`FIFO_DEPTH),
        .ADDR_WIDTH (`FIFO_ADDR_WIDTH)
    ) u_word_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (cs_rise),
        .in_ready  (fifo_in_ready),
        .in_data   (frame_word),
        .out_valid (fifo_out_valid),
        .out_ready (converter_ready),
        .out_data  (fifo_out_data),
        .level     ()
    );

    assign fifo_pop   = fifo_out_valid & converter_ready;
    assign load_ready = fifo_in_ready;

    // ------------------------------------------------------------
    // frame status pulses
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dropped_reg <= `PULSE_RESET;
            short_reg   <= `PULSE_RESET;
        end else begin
            dropped_reg <= cs_rise & ~fifo_in_ready;
            short_reg   <= cs_rise & (bit_count_reg < `MIN_FRAME_BITS);
        end
    end

    assign frame_dropped = dropped_reg;
    assign frame_short   = short_reg;

    // ------------------------------------------------------------
    // dac register
    // ------------------------------------------------------------
    reg  [`LATCH_WIDTH-1:0]      latch_reg;
    reg  [`LATCH_WIDTH-1:0]      latch_next;
    reg                          update_reg;

    always @* begin
        latch_next = latch_reg;
        if (fifo_pop) begin
            latch_next = fifo_out_data;
        end
    end

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            latch_reg  <= `LATCH_RESET;
            update_reg <= `PULSE_RESET;
        end else begin
            latch_reg  <= latch_next;
            update_reg <= fifo_pop;
        end
    end

    assign dac_latch  = latch_reg;
    // straight binary code, sub-lsb bits dropped
    assign dac_code   = latch_reg[`CODE_MSB:`CODE_LSB];
    assign dac_update = update_reg;

endmodule // serial_dac_word_loader

`default_nettype wire

// *** test/loader_props.sv ***
// assertion checker bound to the serial dac word loader
`include "serial_dac_word_loader_defines.vh"
`default_nettype none
module loader_props (
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    reset,
    // serial pins
    input wire logic                    chip_select_n,
    input wire logic                    serial_clock,
    input wire logic                    serial_data_in,
    input wire logic                    serial_data_out,
    // core side and status
    input wire logic                    converter_ready,
    input wire logic [`LATCH_WIDTH-1:0] dac_latch,
    input wire logic [`CODE_WIDTH-1:0]  dac_code,
    input wire logic                    dac_update,
    input wire logic                    load_ready,
    input wire logic                    frame_dropped,
    input wire logic                    frame_short
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        reset |=> dac_latch == `LATCH_RESET && !serial_data_out && load_ready)
        else $error("state not cleared in reset");
    AST_CODE_MAP: assert property (dac_code == dac_latch[`CODE_MSB:`CODE_LSB])
        else $error("code differs from latch data bits");
    AST_UPDATE_PULSE: assert property ($changed(dac_latch) |-> dac_update)
        else $error("no update pulse after latch change");
    AST_UPDATE_CAUSE: assert property (dac_update |-> $past(converter_ready))
        else $error("update without converter ready");
    AST_LATCH_HOLD: assert property (!converter_ready |=> $stable(dac_latch))
        else $error("latch moved while converter not ready");
    AST_DOUT_HOLD: assert property (chip_select_n [*5] |-> $stable(serial_data_out))
        else $error("data out moved while deselected");
    AST_DOUT_EDGE: assert property ($changed(serial_data_out)
        |-> !serial_clock && !$past(serial_clock, 2))
        else $error("data out moved away from a falling clock");
    AST_DROP_FULL: assert property (frame_dropped |-> !load_ready || !$past(load_ready))
        else $error("frame dropped with room in fifo");
    AST_SHORT_PULSE: assert property (frame_short |=> !frame_short)
        else $error("short frame flag longer than one cycle");
endmodule // loader_props
bind serial_dac_word_loader loader_props chk (.clk_sys(clk_sys), .reset(reset),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .converter_ready(converter_ready), .dac_latch(dac_latch), .dac_code(dac_code),
    .dac_update(dac_update), .load_ready(load_ready), .frame_dropped(frame_dropped),
    .frame_short(frame_short));
`default_nettype wire

// *** test/dac_host_model.sv ***
// host model driving the three wire serial load bus
`default_nettype none
module dac_host_model (
    // clock
    input wire logic clk_sys,
    // serial pins
    output logic     chip_select_n,
    output logic     serial_clock,
    output logic     serial_data_in,
    input wire logic serial_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;   // clock starts low; only stray pulses it while deselected
        serial_data_in = 1'b0;
    end
    // idle data line never shows a stale value
    always @(negedge clk_sys) if (!busy) serial_data_in <= ~serial_data_in;
    // one frame of n bits, msb first, collecting data out
    task automatic send(input int n, input logic [15:0] v, output logic [15:0] rx);
        busy = 1'b1;
        rx = 16'h0000;
        @(negedge clk_sys);
        chip_select_n = 1'b0;   // cs moves with clock low
        repeat (3) @(negedge clk_sys);
        for (int i = n - 1; i >= 0; i--) begin   // ten to sixteen bit frames
            serial_data_in = v[i];
            @(negedge clk_sys);
            serial_clock = 1'b1;
            repeat (4) @(negedge clk_sys);
            serial_clock = 1'b0;
            repeat (3) @(negedge clk_sys);
            rx = {rx[14:0], serial_data_out};
        end
        chip_select_n = 1'b1;
        repeat (6) @(negedge clk_sys);   // six deselected cycles between frames
        busy = 1'b0;
    endtask
    // clock pulses while deselected, must be ignored
    task automatic stray(input int k);
        repeat (k) begin
            repeat (4) @(negedge clk_sys);
            serial_clock = 1'b1;
            repeat (4) @(negedge clk_sys);
            serial_clock = 1'b0;
        end
    endtask
endmodule // dac_host_model
`default_nettype wire

// *** test/serial_dac_word_loader_tb.sv ***
// self-checking bench for the serial dac word loader
`include "serial_dac_word_loader_defines.vh"
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module serial_dac_word_loader_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic converter_ready = 1'b1;
    logic saw_drop = 1'b0;
    logic saw_short = 1'b0;
    wire logic chip_select_n, serial_clock, serial_data_in, serial_data_out;
    wire logic dac_update, load_ready, frame_dropped, frame_short;
    wire logic [`LATCH_WIDTH-1:0] dac_latch;
    wire logic [`CODE_WIDTH-1:0] dac_code;
    int err_total = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h0000ca60;
    logic [31:0] r;
    logic [15:0] shadow, rx;
    logic [15:0] q [8];
    logic [9:0] codes [4] = '{10'h3ff, 10'h200, 10'h000, 10'h201};
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (frame_dropped === 1'b1) saw_drop <= 1'b1;
    always @(posedge clk_sys) if (frame_short === 1'b1) saw_short <= 1'b1;
    dac_host_model host (.clk_sys(clk_sys), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out));
    serial_dac_word_loader dut (.clk_sys(clk_sys), .reset(reset),
        .chip_select_n(chip_select_n), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .converter_ready(converter_ready), .dac_latch(dac_latch), .dac_code(dac_code),
        .dac_update(dac_update), .load_ready(load_ready), .frame_dropped(frame_dropped),
        .frame_short(frame_short));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // new shift contents on top, expected data out bits below
    function automatic logic [31:0] expect_frame(logic [15:0] p, int n, logic [15:0] v);
        logic [31:0] cat;
        logic [31:0] back;
        cat = {p, 16'(v << (16 - n))};
        back = (cat >> (31 - n)) & ((32'h1 << n) - 1);
        cat = cat << n;
        return {cat[31:16], back[15:0]};
    endfunction
    task automatic frame(input int n, input logic [15:0] v, input bit chk);
        logic [31:0] e;
        e = expect_frame(shadow, n, v);
        host.send(n, v, rx);
        `CHK("dout bits", e[15:0], rx)
        shadow = e[31:16];
        if (chk) begin
            repeat (2) @(negedge clk_sys);
            `CHK("latch", shadow[11:0], dac_latch)
            `CHK("code", shadow[11:2], dac_code)
        end
    endtask
    task automatic do_reset();
        reset = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK("reset latch", 12'h000, dac_latch)
        `CHK("reset dout", 1'b0, serial_data_out)
        reset = 1'b0;
        shadow = 16'h0000;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(40000 * 40);
        err_total++;
        results();
    end
    initial begin
        do_reset();
        foreach (codes[i]) begin
            r = xs();
            frame(16, {r[3:0], codes[i], 2'b00}, 1);   // dummy bits lead
            `CHK("corner code", codes[i], dac_code)
            frame(12, {4'h0, codes[i], 2'b00}, 1);
        end
        repeat (20) begin
            r = xs();
            frame(r[0] ? 16 : 12, {r[17:4], 2'b00}, 1);
        end
        frame(14, {r[21:8], 2'b00}, 1);   // fourteen bit frame loads last twelve
        host.stray(3);
        repeat (8) @(negedge clk_sys);
        `CHK("stray latch", shadow[11:0], dac_latch)
        `CHK("short none", 1'b0, saw_short)
        r = xs();
        frame(10, {r[29:16], 2'b00}, 1);   // short frame still loads
        `CHK("short seen", 1'b1, saw_short)
        converter_ready = 1'b0;
        for (int j = 0; j < 9; j++) begin
            r = xs();
            frame(16, {r[15:2], 2'b00}, 0);
            if (j < 8) q[j] = shadow;
        end
        `CHK("full ready", 1'b0, load_ready)
        `CHK("drop seen", 1'b1, saw_drop)
        for (int j = 0; j < 8; j++) begin
            converter_ready = 1'b1;
            @(negedge clk_sys);
            converter_ready = 1'b0;
            `CHK("drain latch", q[j][11:0], dac_latch)
            `CHK("drain update", 1'b1, dac_update)
            @(negedge clk_sys);
        end
        converter_ready = 1'b1;
        do_reset();
        frame(16, 16'h5a5c, 1);
        results();
    end
endmodule // serial_dac_word_loader_tb
`default_nettype wire
